// ---- txcs_pkg.sv ----
/*
 Package for the transmitter control and status register slice.
 Holds register indices, field positions, reset values and timing constants.
 Assumes a single 32 MHz crystal-derived core clock domain.
*/
package txcs_pkg;
	localparam logic [7:0] TXCS_ADDR_STATUS   = 8'h14;
	localparam logic [7:0] TXCS_ADDR_CONTROL  = 8'h15;
	localparam logic [7:0] TXCS_ADDR_CHECKSUM = 8'h16;
	localparam logic [7:0] TXCS_CONTROL_RESET  = 8'h00;
	localparam logic [7:0] TXCS_CHECKSUM_RESET = 8'h00;
	localparam int TXCS_BIT_PLL_LOST   = 0;
	localparam int TXCS_BIT_VCO_ERR    = 1;
	localparam int TXCS_BIT_UNDERVOLT  = 2;
	localparam int TXCS_BIT_OSC_OK     = 3;
	localparam int TXCS_CNT_LSB        = 4;
	localparam int TXCS_BIT_PLL_STBY   = 0;
	localparam int TXCS_INTERFACE_SELECT_LSB      = 3;
	localparam int TXCS_BIT_FS_OFF     = 5;
	localparam int TXCS_BIT_CK_TRI     = 6;
	localparam int TXCS_BIT_FAST_PD    = 7;
	localparam logic [7:0] TXCS_CONTROL_RW_MASK = 8'h79;
	localparam logic [1:0] TXCS_IF_INVALID = 2'h3;
	// Enable-low hold time before slow powerdown, in crystal clock cycles.
	localparam int TXCS_PD_HOLD_LOG2   = 18;
	localparam int TXCS_PD_HOLD_CYCLES = 1 << TXCS_PD_HOLD_LOG2;
	typedef enum logic [1:0] {
		TXCS_OSC_ACTIVE = 2'b00,
		TXCS_PLL_STBY   = 2'b01
	} txcs_mode_e;
endpackage

// ---- txcs_pd_timer.sv ----
/*
 Enable-low hold timer for slow powerdown entry.
 Assumes enable_low is already synchronised to core_clk.
*/
`timescale 1ns/1ns
module txcs_pd_timer
	import txcs_pkg::*;
#(
	parameter int HOLD_CYCLES = TXCS_PD_HOLD_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic enable_low,
	output logic      expired
);
	localparam int W = $clog2(HOLD_CYCLES + 1);
	// A hold of zero would expire at once and defeat the slow powerdown delay.
	if (HOLD_CYCLES < 1) begin : g_hold_check
		$error("HOLD_CYCLES must be at least one");
	end

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// Counting restarts on any high sample, so only a continuous low period expires.
	always_comb begin
		cnt_d = cnt_q;
		if (!enable_low)
			cnt_d = '0;
		else if (cnt_q != W'(HOLD_CYCLES))
			cnt_d = cnt_q + W'(1);
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	assign expired = (cnt_q == W'(HOLD_CYCLES));
endmodule

// ---- txcs_regs.sv ----
/*
 Control and status registers of the transmitter: status flags with entry
 counter, transmitter control and serial checksum, plus powerdown request.
 Assumes a serial front end delivers decoded register accesses and every
 address or data byte on core_clk, and analog monitors give synchronous pulses
 except the enable pin, which is sampled through two flip-flops here.
*/
// Functional notes
// R1 - Status bit 3 shows crystal amplitude check, 1 meaning sufficient.
// R2 - Status bit 2 is the sticky under-voltage flag.
// R3 - Status bit 1 is the sticky VCO calibration error flag.
// R4 - Status bit 0 is the sticky PLL loss-of-lock flag.
// R5 - Slow select: powerdown after enable held low for 2^18 clocks.
// R6 - Fast select: powerdown immediately when enable goes low.
// R7 - Control bit 6 set puts the clock output pin in high impedance.
// R8 - Control bit 5 set disables the fail-safe function.
// R9 - Two-bit field selects serial mode and data pin; 11b never written.
// R10 - Writing standby request 1 in oscillator-active mode enters PLL standby.
// R11 - Writing standby request 0 in PLL standby returns to oscillator-active.
// R12 - Checksum holds XOR of all serial address and data bytes.
// R13 - Fast select is write-only; other control bits read back; reset zero.
// R14 - Status bits 7:4 count transmitter-active entries, wrapping at overflow.
// R15 - Reading the checksum clears it to zero.
// R16 - Error flags stay set until a status read clears them.
`timescale 1ns/1ns
module txcs_regs
	import txcs_pkg::*;
#(
	parameter int PD_HOLD_CYCLES = TXCS_PD_HOLD_CYCLES
) (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       byte_valid,
	input  wire logic [7:0] byte_data,
	input  wire logic       osc_amplitude_ok,
	input  wire logic       undervoltage_evt,
	input  wire logic       vco_cal_error_evt,
	input  wire logic       pll_lock_lost_evt,
	input  wire logic       tx_active_entry,
	input  wire logic       enable_pin,
	output logic            powerdown_req,
	output logic            clock_out_tristate,
	output logic            failsafe_disable,
	output logic      [1:0] interface_select,
	output logic            pll_standby
);
	logic       flags_ok_q, uv_q, vco_q, pll_q;
	logic       uv_d, vco_d, pll_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] sum_q, sum_d;
	logic [7:0] rdata_q, rdata_d;
	txcs_mode_e mode_q, mode_d;
	logic       en_s1_q, en_s2_q, en_prev_q;
	logic       pd_q, pd_d;
	logic       slow_expired;
	logic       wr_ctrl, rd_stat, rd_sum;

	assign wr_ctrl = reg_wr && (reg_addr == TXCS_ADDR_CONTROL);
	assign rd_stat = reg_rd && (reg_addr == TXCS_ADDR_STATUS);
	assign rd_sum  = reg_rd && (reg_addr == TXCS_ADDR_CHECKSUM);

	// Sticky flags; an event in the clearing read cycle wins over the clear.
	always_comb begin
		uv_d  = (uv_q  && !rd_stat) || undervoltage_evt;  // R2 R16
		vco_d = (vco_q && !rd_stat) || vco_cal_error_evt; // R3 R16
		pll_d = (pll_q && !rd_stat) || pll_lock_lost_evt; // R4 R16
		cnt_d = tx_active_entry ? cnt_q + 4'h1 : cnt_q;   // R14
	end

	// Control register; the invalid interface code is kept out of the field.
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = reg_wdata & (TXCS_CONTROL_RW_MASK | 8'h80);
			if (reg_wdata[TXCS_INTERFACE_SELECT_LSB+:2] == TXCS_IF_INVALID) // R9
				ctrl_d[TXCS_INTERFACE_SELECT_LSB+:2] = ctrl_q[TXCS_INTERFACE_SELECT_LSB+:2];
		end
	end

	// Mode follows the standby request bit, only on writes.
	always_comb begin
		mode_d = mode_q;
		if (wr_ctrl) begin
			if (mode_q == TXCS_OSC_ACTIVE && reg_wdata[TXCS_BIT_PLL_STBY]) // R10
				mode_d = TXCS_PLL_STBY;
			else if (mode_q == TXCS_PLL_STBY && !reg_wdata[TXCS_BIT_PLL_STBY]) // R11
				mode_d = TXCS_OSC_ACTIVE;
		end
	end

	// Checksum; a byte arriving with the clearing read starts the new sum.
	always_comb begin
		sum_d = rd_sum ? 8'h00 : sum_q; // R15
		if (byte_valid)
			sum_d = sum_d ^ byte_data; // R12
	end

	// Read mux; the write-only fast-select bit reads as zero.
	always_comb begin
		rdata_d = 8'h00;
		if (rd_stat)
			rdata_d = {cnt_q, flags_ok_q, uv_q, vco_q, pll_q}; // R1
		else if (reg_rd && reg_addr == TXCS_ADDR_CONTROL)
			rdata_d = ctrl_q & TXCS_CONTROL_RW_MASK; // R13
		else if (rd_sum)
			rdata_d = sum_q;
	end

	// Powerdown: fast on the falling edge, slow after a continuous low hold.
	always_comb begin
		pd_d = pd_q;
		if (en_s2_q)
			pd_d = 1'b0;
		else if (ctrl_q[TXCS_BIT_FAST_PD] && en_prev_q) // R6
			pd_d = 1'b1;
		else if (!ctrl_q[TXCS_BIT_FAST_PD] && slow_expired) // R5
			pd_d = 1'b1;
	end

	txcs_pd_timer #(
		.HOLD_CYCLES (PD_HOLD_CYCLES)
	) u_pd_timer (
		.core_clk   (core_clk),
		.reset      (reset),
		.enable_low (!en_s2_q),
		.expired    (slow_expired)
	);

	// State registers.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			flags_ok_q <= 1'b0;
			uv_q       <= 1'b0;
			vco_q      <= 1'b0;
			pll_q      <= 1'b0;
			cnt_q      <= 4'h0;
			ctrl_q     <= TXCS_CONTROL_RESET; // R13
			sum_q      <= TXCS_CHECKSUM_RESET;
			rdata_q    <= 8'h00;
			mode_q     <= TXCS_OSC_ACTIVE;
			en_s1_q    <= 1'b0;
			en_s2_q    <= 1'b0;
			en_prev_q  <= 1'b0;
			pd_q       <= 1'b0;
		end else begin
			flags_ok_q <= osc_amplitude_ok; // R1
			uv_q       <= uv_d;
			vco_q      <= vco_d;
			pll_q      <= pll_d;
			cnt_q      <= cnt_d;
			ctrl_q     <= ctrl_d;
			sum_q      <= sum_d;
			rdata_q    <= rdata_d;
			mode_q     <= mode_d;
			en_s1_q    <= enable_pin;
			en_s2_q    <= en_s1_q;
			en_prev_q  <= en_s2_q;
			pd_q       <= pd_d;
		end
	end

	assign reg_rdata          = rdata_q;
	assign powerdown_req      = pd_q;
	assign clock_out_tristate = ctrl_q[TXCS_BIT_CK_TRI]; // R7
	assign failsafe_disable   = ctrl_q[TXCS_BIT_FS_OFF]; // R8
	assign interface_select   = ctrl_q[TXCS_INTERFACE_SELECT_LSB+:2]; // R9
	assign pll_standby        = (mode_q == TXCS_PLL_STBY);

	property flag_hold_p(logic f);
		@(posedge core_clk) disable iff (reset) f && !rd_stat |=> f;
	endproperty
	uv_sticky_a: assert property (flag_hold_p(uv_q)) else $error("uv flag dropped"); // R2
	vco_sticky_a: assert property (flag_hold_p(vco_q)) else $error("vco flag dropped"); // R3
	pll_sticky_a: assert property (flag_hold_p(pll_q)) else $error("pll flag dropped"); // R4
	flag_clear_a: assert property (@(posedge core_clk) disable iff (reset) // R16
		rd_stat && !pll_lock_lost_evt |=> !pll_q) else $error("flag not cleared");
	// A new event must survive the clearing read that meets it.
	flag_set_wins_a: assert property (@(posedge core_clk) disable iff (reset) // R16
		rd_stat && undervoltage_evt |=> uv_q) else $error("flag set lost to clear");
	count_wrap_a: assert property (@(posedge core_clk) disable iff (reset) // R14
		tx_active_entry && cnt_q == 4'hf |=> cnt_q == 4'h0) else $error("count no wrap");

	// A falling edge is one cycle with the delayed copy high and the synchronised pin low.
	sequence en_fall_s;
		en_prev_q && !en_s2_q;
	endsequence
	fast_pd_a: assert property (@(posedge core_clk) disable iff (reset) // R6
		(en_fall_s and ctrl_q[7]) |=> pd_q) else $error("fast powerdown late");
	// Slow select must never raise the request before the hold timer runs out.
	slow_early_a: assert property (@(posedge core_clk) disable iff (reset) // R5
		!ctrl_q[7] && !slow_expired && !pd_q |=> !pd_q) else $error("slow powerdown early");
	slow_pd_a: assert property (@(posedge core_clk) disable iff (reset) // R5
		!ctrl_q[7] && slow_expired && !en_s2_q |=> pd_q) else $error("slow pd");
	pd_release_a: assert property (@(posedge core_clk) disable iff (reset) // R6
		en_s2_q |=> !pd_q) else $error("powerdown held while enabled");

	sum_clear_a: assert property (@(posedge core_clk) disable iff (reset) // R15
		rd_sum && !byte_valid |=> sum_q == 8'h00) else $error("checksum not cleared");
	sum_restart_a: assert property (@(posedge core_clk) disable iff (reset) // R15
		rd_sum && byte_valid |=> sum_q == $past(byte_data)) else $error("checksum restart");
	sum_xor_a: assert property (@(posedge core_clk) disable iff (reset) // R12
		!rd_sum && byte_valid |=> sum_q == ($past(sum_q) ^ $past(byte_data)))
		else $error("checksum wrong");
	fast_read_a: assert property (@(posedge core_clk) disable iff (reset) // R13
		reg_rd && reg_addr == TXCS_ADDR_CONTROL |=> !reg_rdata[7])
		else $error("write-only bit read");
	stby_enter_a: assert property (@(posedge core_clk) disable iff (reset) // R10
		wr_ctrl && reg_wdata[0] |=> pll_standby) else $error("standby not entered");
	stby_exit_a: assert property (@(posedge core_clk) disable iff (reset) // R11
		wr_ctrl && !reg_wdata[0] |=> !pll_standby) else $error("standby not left");
	mode_hold_a: assert property (@(posedge core_clk) disable iff (reset) // R10 R11
		!wr_ctrl |=> $stable(mode_q)) else $error("mode moved without a write");
	tristate_a: assert property (@(posedge core_clk) disable iff (reset) // R7
		wr_ctrl |=> clock_out_tristate == $past(reg_wdata[6])) else $error("ck tri");
	failsafe_a: assert property (@(posedge core_clk) disable iff (reset) // R8
		wr_ctrl |=> failsafe_disable == $past(reg_wdata[5])) else $error("fs off");
	interface_select_valid_a: assert property (@(posedge core_clk) disable iff (reset) // R9
		interface_select != 2'h3) else $error("invalid interface mode");
	// The edge that releases reset still loads the reset value, so it is skipped.
	osc_a: assert property (@(posedge core_clk) disable iff (reset) // R1
		!reset |=> flags_ok_q == $past(osc_amplitude_ok)) else $error("osc flag");
endmodule

// ---- txcs_host.sv ----
/*
 Behavioural serial host that issues decoded register accesses and checksum
 bytes. Assumes it shares core_clk with the register slice.
*/
`timescale 1ns/1ns
module txcs_host (
	input  wire logic       core_clk,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            byte_valid,
	output logic      [7:0] byte_data
);
	// Idle values at time zero; strobes stay low between accesses.
	initial begin
		{reg_wr, reg_rd, byte_valid} = 3'h0;
		{reg_addr, reg_wdata, byte_data} = 24'h0;
	end

	// One access per call, strobe held for one edge; data is inverted after
	// release so that a stale value is never mistaken for a live one.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// One address or data byte of a serial transfer.
	task automatic send(input logic [7:0] b);
		@(posedge core_clk);
		byte_valid <= 1'b1;
		byte_data <= b;
		@(posedge core_clk);
		byte_valid <= 1'b0;
		byte_data <= ~b;
	endtask
endmodule

// ---- testbench.sv ----
/*
 Self-checking bench for the register slice with a reference model.
 Assumes the slice is run with a short powerdown hold count.
*/
`timescale 1ns/1ns
module testbench;
	import txcs_pkg::*;
	localparam int HOLD = 8;
	logic       core_clk, reset, reg_wr, reg_rd, byte_valid, osc_ok, uv, vco, lol;
	logic       tx_ent, en_pin, pd_req, ck_tri, fs_off, stby;
	logic [7:0] reg_addr, reg_wdata, byte_data, reg_rdata, ctl, b;
	logic [1:0] if_sel;
	int         fail_count, tests_run, cyc, cnt, n;
	byte        sent[$];

	txcs_host u_txcs_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .byte_valid(byte_valid),
		.byte_data(byte_data));
	txcs_regs #(.PD_HOLD_CYCLES(HOLD)) u_txcs_regs (.core_clk(core_clk), .reset(reset),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .byte_valid(byte_valid), .byte_data(byte_data),
		.osc_amplitude_ok(osc_ok), .undervoltage_evt(uv), .vco_cal_error_evt(vco),
		.pll_lock_lost_evt(lol), .tx_active_entry(tx_ent), .enable_pin(en_pin),
		.powerdown_req(pd_req), .clock_out_tristate(ck_tri),
		.failsafe_disable(fs_off), .interface_select(if_sel), .pll_standby(stby));

	// Free-running 20 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// A hang is cut short well past the expected run length.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Read data is registered, so it is sampled mid-cycle after the taking edge.
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		u_txcs_host.acc(1'b0, a, 8'h00);
		@(negedge core_clk);
		chk(nm, e, reg_rdata);
	endtask

	// Model of a control write: the invalid interface code keeps the old field.
	task automatic wctl(input logic [7:0] d);
		u_txcs_host.acc(1'b1, TXCS_ADDR_CONTROL, d);
		if (d[4:3] != TXCS_IF_INVALID)
			ctl[4:3] = d[4:3];
		ctl = {1'b0, d[6:5], ctl[4:3], 2'b00, d[0]};
		@(negedge core_clk);
		chk("ctl_out", ctl, {1'b0, ck_tri, fs_off, if_sel, 2'b00, stby});
	endtask

	task automatic pin_chk(input int w, input logic e, input string nm);
		repeat (w) @(posedge core_clk);
		@(negedge core_clk);
		chk(nm, {7'h0, e}, {7'h0, pd_req});
	endtask

	// Main sequence.
	initial begin
		void'($urandom(32'h7246));
		{reset, en_pin} = 2'b11;
		{osc_ok, uv, vco, lol, tx_ent} = 5'h0;
		{ctl, cnt} = 0;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		@(negedge core_clk);
		chk("ctl_out", 8'h00, {1'b0, ck_tri, fs_off, if_sel, 2'b00, stby});
		rd(TXCS_ADDR_CONTROL, 8'h00, "ctl_reset");
		rd(8'h40, 8'h00, "unmapped");
		for (int i = 0; i < 24; i++) begin
			wctl(8'($urandom));
			rd(TXCS_ADDR_CONTROL, ctl, "ctl_read");
		end
		u_txcs_host.acc(1'b1, TXCS_ADDR_CHECKSUM, 8'hff);
		for (int i = 0; i < 6; i++) begin
			sent.push_back(byte'($urandom));
			u_txcs_host.send(8'(sent[i]));
		end
		b = 8'h00;
		foreach (sent[i])
			b ^= 8'(sent[i]);
		rd(TXCS_ADDR_CHECKSUM, b, "checksum");
		rd(TXCS_ADDR_CHECKSUM, 8'h00, "sum_clear");
		// Each pass raises one flag and a batch of 9 to 20 entries; the count wraps by the second pass.
		for (int k = 0; k < 3; k++) begin
			n = $urandom_range(20, 9);
			cnt += n;
			repeat (n) begin
				@(posedge core_clk) tx_ent <= 1'b1;
				@(posedge core_clk) tx_ent <= 1'b0;
			end
			osc_ok <= !k[0];
			{uv, vco, lol} <= 3'(1 << k);
			@(posedge core_clk) {uv, vco, lol} <= 3'h0;
			repeat (3) @(posedge core_clk);
			rd(TXCS_ADDR_STATUS, {4'(cnt), !k[0], 3'(1 << k)}, "status");
			rd(TXCS_ADDR_STATUS, {4'(cnt), !k[0], 3'h0}, "status_clr");
		end
		wctl(8'h80);
		@(posedge core_clk) en_pin <= 1'b0;
		pin_chk(2, 1'b0, "pd_fast_early");
		pin_chk(1, 1'b1, "pd_fast");
		@(posedge core_clk) en_pin <= 1'b1;
		pin_chk(4, 1'b0, "pd_release");
		wctl(8'h00);
		@(posedge core_clk) en_pin <= 1'b0;
		repeat (HOLD - 2) @(posedge core_clk);
		en_pin <= 1'b1;
		pin_chk(4, 1'b0, "pd_glitch");
		// Two sync flops, HOLD timer samples and the request flop set the end point.
		@(posedge core_clk) en_pin <= 1'b0;
		pin_chk(HOLD + 2, 1'b0, "pd_early");
		pin_chk(1, 1'b1, "pd_slow");
		summarize();
	end
endmodule
